// file: rtl/rxrp_cfg.svh
`ifndef RXRP_CFG_SVH
`define RXRP_CFG_SVH
// register byte offsets
`define RXRP_ADDR_CFG 8'h00
`define RXRP_ADDR_THRESH 8'h04
`define RXRP_ADDR_STATUS 8'h08
// config field positions
`define RXRP_CFG_PORT_LSB 0
`define RXRP_CFG_PORT_MSB 2
`define RXRP_CFG_PKT_BIT 4
`define RXRP_CFG_EARLY_BIT 5
`define RXRP_CFG_INV_BIT 6
// reset values
`define RXRP_PORT_RESET 3'h0
`define RXRP_THRESH_RESET 8'h20
// null port code, never matches
`define RXRP_NULL_PORT 3'h7
// cell layout in words
`define RXRP_HDR_WORDS 5'h03
`define RXRP_DROP_LATE 5'h18
`define RXRP_DROP_EARLY 5'h13
// odd parity on the word bus
`define RXRP_ODD_PARITY 1'b1
`endif

// file: rtl/rxrp_pkg.sv
`default_nettype none
package rxrp_pkg;
  typedef logic [2:0] rxrp_port_t;
  typedef struct packed {
    logic [15:0] data;
    logic start;
    logic eop;
    logic one_byte;
    logic abort;
  } rxrp_entry_s;
endpackage : rxrp_pkg
`default_nettype wire

// file: rtl/rxrp_sync.sv
`default_nettype none
module rxrp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : rxrp_sync
`default_nettype wire

// file: rtl/rxrp_fifo.sv
`default_nettype none
module rxrp_fifo #(
  parameter int WIDTH = 20,
  parameter int AW = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // drain side, head and the entry behind it
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic [WIDTH-1:0] peek,
  output logic [AW:0] level
);
  localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  wire do_wr = wr_valid && wr_ready;
  wire do_rd = pop && (level != '0);
  wire [AW-1:0] rd_ptr_inc = rd_ptr + 1'b1;

  assign wr_ready = (level != DEPTH);
  assign head = mem[rd_ptr];
  assign peek = mem[rd_ptr_inc];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr_inc;
      end
      level <= level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : rxrp_fifo
`default_nettype wire

// file: rtl/rxrp_top.sv
// Functional notes
// - Word bus, markers, byte count, parity and abort are valid while word valid is high.
// - Word valid drops when the FIFO runs empty or after a packet end.
// - Nothing leaves the receive FIFO while word valid is low.
// - Once dropped on a read (packet end or FIFO empty), word valid stays low until read enable goes off.
// - Word valid floats when read enable is off or the port code misses.
// - Valid, byte count and both avail outputs change only on read clock rises.
// - In cell mode, cell avail shows a cell waiting in this FIFO.
// - Cell avail drops after payload word 24 or 19, chosen by early level.
// - In packet mode, packet avail is high on a held end or enough bytes.
// - Packet avail polarity flips when the invert bit is set.
// - Packet words carry two bytes except the last, which carries one or two.
// - Byte count high means one byte in the upper half, low means two.
// - Byte count used only in packet mode, floats when disabled or unaddressed.
// - Read select is sampled on read clock rises while read enable is off to choose the port.
// - Port addressed only when select equals our code; code 7 never matches.
// - Byte count is shown in the same cycle as the packet end marker.
`include "rxrp_cfg.svh"
`default_nettype none
module rxrp_top #(
  parameter int AW = 6
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive data into the FIFO
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_data,
  input wire logic in_start,
  input wire logic in_end,
  input wire logic in_one_byte,
  input wire logic in_abort,
  // link inputs
  input wire logic rx_fifo_read_clock,
  input wire logic rx_read_enable_n,
  input wire logic [2:0] rx_read_select,
  // link outputs with drive enables
  output logic [15:0] rx_word_bus,
  output logic rx_packet_start,
  output logic rx_packet_end,
  output logic rx_packet_abort,
  output logic rx_word_parity,
  output logic rx_word_bus_oe,
  output logic rx_word_valid,
  output logic rx_word_valid_oe,
  output logic last_word_byte_count,
  output logic last_word_byte_count_oe,
  // direct status
  output logic direct_cell_avail,
  output logic direct_packet_avail
);
  function automatic logic word_parity(input logic [15:0] w);
    word_parity = (^w) ^ `RXRP_ODD_PARITY;
  endfunction : word_parity

  // configuration registers
  rxrp_pkg::rxrp_port_t phy_select_code;
  logic packet_mode;
  logic cell_avail_early_level;
  logic packet_avail_invert;
  logic [7:0] pa_thresh;

  // link input synchronisation and edge finding
  logic [4:0] sync_q;
  logic clk_q;
  logic [3:0] ctl_q;

  rxrp_sync #(.W(5)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({rx_fifo_read_clock, rx_read_enable_n, rx_read_select}),
    .q(sync_q)
  );

  // control sampled one cycle before the seen edge, i.e. before it moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
      ctl_q <= 4'hF;
    end else begin
      clk_q <= sync_q[4];
      ctl_q <= sync_q[3:0];
    end
  end

  wire rf_rise = sync_q[4] && !clk_q;
  wire enabled = !ctl_q[3];
  wire [2:0] sel_s = ctl_q[2:0];

  // port address latched while read enable is off
  rxrp_pkg::rxrp_port_t addr_latched;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_latched <= `RXRP_NULL_PORT;
    end else if (rf_rise && !enabled) begin
      addr_latched <= sel_s;
    end
  end

  wire port_hit = (addr_latched == phy_select_code) && (addr_latched != `RXRP_NULL_PORT);
  wire drive = enabled && port_hit;

  // receive FIFO
  rxrp_pkg::rxrp_entry_s head;
  rxrp_pkg::rxrp_entry_s peek;
  rxrp_pkg::rxrp_entry_s in_ent;
  logic [AW:0] level;
  logic pop;

  assign in_ent = '{data: in_data, start: in_start, eop: in_end,
                    one_byte: in_one_byte, abort: in_abort};

  rxrp_fifo #(.WIDTH($bits(rxrp_pkg::rxrp_entry_s)), .AW(AW)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data(in_ent),
    .pop(pop),
    .head(head),
    .peek(peek),
    .level(level)
  );

  // presentation of the next word
  logic hold;
  assign pop = rf_rise && drive && rx_word_valid;
  wire next_avail = pop ? (level >= (AW+1)'(2)) : (level != '0);
  rxrp_pkg::rxrp_entry_s next_ent;
  assign next_ent = pop ? peek : head;
  wire hold_set = pop && ((packet_mode && head.eop) || !next_avail);
  wire next_hold = enabled && (hold || hold_set);
  wire next_valid = drive && !next_hold && next_avail;
  wire next_short = packet_mode && next_ent.eop && next_ent.one_byte;
  wire [15:0] next_bus = next_short ? {next_ent.data[15:8], 8'h00} : next_ent.data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 1'b0;
      rx_word_valid <= 1'b0;
      rx_word_valid_oe <= 1'b0;
      rx_word_bus_oe <= 1'b0;
      last_word_byte_count_oe <= 1'b0;
      last_word_byte_count <= 1'b0;
      rx_word_bus <= 16'h0000;
      rx_packet_start <= 1'b0;
      rx_packet_end <= 1'b0;
      rx_packet_abort <= 1'b0;
      rx_word_parity <= 1'b0;
    end else if (rf_rise) begin
      hold <= next_hold;
      rx_word_valid <= next_valid;
      rx_word_valid_oe <= drive;
      rx_word_bus_oe <= drive;
      last_word_byte_count_oe <= drive && packet_mode;
      last_word_byte_count <= next_short;
      rx_word_bus <= next_bus;
      rx_packet_start <= packet_mode && next_ent.start;
      rx_packet_end <= packet_mode && next_ent.eop;
      rx_packet_abort <= packet_mode && next_ent.eop && next_ent.abort;
      rx_word_parity <= word_parity(next_bus);
    end
  end

  // held ends (packets or whole cells) and position inside the cell
  logic [AW:0] ends_held;
  logic cell_active;
  logic [4:0] word_idx;
  wire end_in = in_valid && in_ready && in_end;
  wire end_out = pop && head.eop;
  wire [AW:0] next_ends = ends_held + (AW+1)'(end_in) - (AW+1)'(end_out);
  wire next_active = pop ? (head.start || cell_active) && !head.eop : cell_active;
  wire [4:0] next_word_idx = !pop ? word_idx :
                             head.eop ? 5'h00 :
                             head.start ? 5'h01 : word_idx + 5'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ends_held <= '0;
      cell_active <= 1'b0;
      word_idx <= 5'h00;
    end else begin
      ends_held <= next_ends;
      cell_active <= next_active;
      word_idx <= next_word_idx;
    end
  end

  // direct status outputs
  wire [4:0] drop_at = `RXRP_HDR_WORDS +
                       (cell_avail_early_level ? `RXRP_DROP_LATE : `RXRP_DROP_EARLY);
  wire cur_cell_done = next_active && (next_word_idx >= drop_at);
  wire cell_raw = (next_ends >= (AW+1)'(2)) ||
                  ((next_ends == (AW+1)'(1)) && !cur_cell_done);
  wire [8:0] level_bytes = 9'({level, 1'b0});
  wire pkt_raw = (next_ends != '0) || (level_bytes >= {1'b0, pa_thresh});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_cell_avail <= 1'b0;
      direct_packet_avail <= 1'b0;
    end else if (rf_rise) begin
      direct_cell_avail <= !packet_mode && cell_raw;
      direct_packet_avail <= packet_mode && (pkt_raw ^ packet_avail_invert);
    end
  end

  // apb register file, zero wait states
  wire hit_cfg = (paddr == `RXRP_ADDR_CFG);
  wire hit_thr = (paddr == `RXRP_ADDR_THRESH);
  wire hit_sts = (paddr == `RXRP_ADDR_STATUS);
  wire hit_any = hit_cfg || hit_thr || hit_sts;
  wire apb_wr = psel && penable && pwrite;
  wire [31:0] cfg_word = {25'h0, packet_avail_invert, cell_avail_early_level,
                          packet_mode, 1'b0, phy_select_code};
  wire [31:0] sts_word = {14'h0, rx_word_valid_oe, rx_word_valid,
                          8'(ends_held), 8'(level)};
  wire [31:0] rd_mux = hit_cfg ? cfg_word :
                       hit_thr ? {24'h0, pa_thresh} :
                       hit_sts ? sts_word : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_select_code <= `RXRP_PORT_RESET;
      packet_mode <= 1'b0;
      cell_avail_early_level <= 1'b0;
      packet_avail_invert <= 1'b0;
      pa_thresh <= `RXRP_THRESH_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      if (psel && !penable) begin
        prdata <= rd_mux;
      end
      if (apb_wr && hit_cfg) begin
        phy_select_code <= pwdata[`RXRP_CFG_PORT_MSB:`RXRP_CFG_PORT_LSB];
        packet_mode <= pwdata[`RXRP_CFG_PKT_BIT];
        cell_avail_early_level <= pwdata[`RXRP_CFG_EARLY_BIT];
        packet_avail_invert <= pwdata[`RXRP_CFG_INV_BIT];
      end
      if (apb_wr && hit_thr) begin
        pa_thresh <= pwdata[7:0];
      end
    end
  end

  // checks
  sequence s_pkt_end_pop;
    rf_rise && pop && packet_mode && head.eop;
  endsequence

  sequence s_last_payload;
    pop && !packet_mode && next_active && (next_word_idx >= drop_at) && (next_ends == 1);
  endsequence

  a_valid_on_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(rx_word_valid) |-> $past(rf_rise))
    else $error("word valid changed off a read clock rise");

  a_status_on_edge: assert property (@(posedge pclk) disable iff (!presetn)
    ($changed(direct_cell_avail) || $changed(direct_packet_avail) ||
     $changed(last_word_byte_count)) |-> $past(rf_rise))
    else $error("status changed off a read clock rise");

  a_no_pop_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (level < $past(level)) |-> $past(rx_word_valid && rx_word_valid_oe && enabled))
    else $error("fifo drained while word valid low");

  a_valid_end_drop: assert property (@(posedge pclk) disable iff (!presetn)
    s_pkt_end_pop |=> !rx_word_valid ##1 !rx_word_valid[*6])
    else $error("word valid stayed high after packet end");

  a_valid_empty_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (rf_rise && pop && level == 1) |=> !rx_word_valid)
    else $error("word valid stayed high on empty fifo");

  a_hold_low: assert property (@(posedge pclk) disable iff (!presetn)
    (rf_rise && hold && enabled && !rx_word_valid) |=> !rx_word_valid)
    else $error("word valid rose before deselect");

  a_float_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (rf_rise && !enabled) |=> !rx_word_valid_oe && !last_word_byte_count_oe)
    else $error("link outputs driven with read enable off");

  a_null_port: assert property (@(posedge pclk) disable iff (!presetn)
    rx_word_valid_oe |-> (addr_latched != `RXRP_NULL_PORT))
    else $error("null port code drove the link");

  a_count_mode: assert property (@(posedge pclk) disable iff (!presetn)
    last_word_byte_count_oe |-> packet_mode)
    else $error("byte count driven outside packet mode");

  a_count_with_end: assert property (@(posedge pclk) disable iff (!presetn)
    last_word_byte_count |-> rx_packet_end && rx_word_bus[7:0] == 8'h00)
    else $error("byte count without packet end or lower half not cleared");

  a_cell_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (rf_rise and s_last_payload) |=> !direct_cell_avail)
    else $error("cell avail stayed high after last payload word");

  a_pkt_held_end: assert property (@(posedge pclk) disable iff (!presetn)
    (rf_rise && packet_mode && next_ends != 0) |=>
      direct_packet_avail == !$past(packet_avail_invert))
    else $error("packet avail wrong with a held end");
endmodule : rxrp_top
`default_nettype wire

// file: verif/rxrp_link_model.sv
`default_nettype none
module rxrp_link_model (
  // bench control
  input wire logic active,
  input wire logic want_read,
  input wire logic [2:0] code,
  // link pins
  output logic rx_fifo_read_clock,
  output logic rx_read_enable_n,
  output logic [2:0] rx_read_select,
  input wire logic [15:0] rx_word_bus,
  input wire logic rx_packet_start,
  input wire logic rx_packet_end,
  input wire logic rx_packet_abort,
  input wire logic rx_word_parity,
  input wire logic rx_word_valid,
  input wire logic rx_word_valid_oe,
  input wire logic last_word_byte_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed;
  logic [20:0] got[$];
  initial begin
    rx_fifo_read_clock = 1'h0;
    rx_read_enable_n = 1'h1;
    rx_read_select = 3'h7;
    armed = 1'h0;
  end
  // stands still while inactive; 200 ns period
  always begin
    #100;
    rx_fifo_read_clock = active ? ~rx_fifo_read_clock : 1'h0;
  end
  always @(posedge rx_fifo_read_clock) begin
    if (!rx_read_enable_n && rx_word_valid_oe && rx_word_valid) begin
      got.push_back({rx_packet_abort, rx_packet_start, rx_packet_end, last_word_byte_count,
        rx_word_parity, rx_word_bus});
    end
    rx_read_select <= code;
    // one deselect edge before each burst
    armed <= want_read;
    rx_read_enable_n <= !(want_read && armed);
  end
endmodule : rxrp_link_model
`default_nettype wire

// file: verif/rx_fifo_read_port_status_bench.sv
`include "rxrp_cfg.svh"
`default_nettype none
module rx_fifo_read_port_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic in_valid, in_ready, in_start, in_end, in_one_byte, in_abort, abort_last;
  logic [15:0] in_data, wbus;
  logic lclk, en_n, active, want_read;
  logic [2:0] sel, code;
  logic w_start, w_end, w_abort, w_par, w_oe, w_valid, w_valid_oe, w_cnt, w_cnt_oe;
  logic cell_av, pkt_av;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  rxrp_top rxrp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_start(in_start), .in_end(in_end), .in_one_byte(in_one_byte), .in_abort(in_abort),
    .rx_fifo_read_clock(lclk), .rx_read_enable_n(en_n), .rx_read_select(sel),
    .rx_word_bus(wbus), .rx_packet_start(w_start), .rx_packet_end(w_end),
    .rx_packet_abort(w_abort), .rx_word_parity(w_par), .rx_word_bus_oe(w_oe),
    .rx_word_valid(w_valid), .rx_word_valid_oe(w_valid_oe), .last_word_byte_count(w_cnt),
    .last_word_byte_count_oe(w_cnt_oe), .direct_cell_avail(cell_av),
    .direct_packet_avail(pkt_av));

  rxrp_link_model rxrp_link_model_inst (.active(active), .want_read(want_read), .code(code),
    .rx_fifo_read_clock(lclk), .rx_read_enable_n(en_n), .rx_read_select(sel),
    .rx_word_bus(wbus), .rx_packet_start(w_start), .rx_packet_end(w_end),
    .rx_packet_abort(w_abort),
    .rx_word_parity(w_par), .rx_word_valid(w_valid), .rx_word_valid_oe(w_valid_oe),
    .last_word_byte_count(w_cnt));

  initial begin
    pclk = 1'h0;
  end
  always #12.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic check_bit(input string what, input logic exp, input logic seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask : check_bit

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_word

  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask : ticks

  task automatic edges(input int n);
    repeat (n) @(posedge lclk);
    ticks(6);
  endtask : edges

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic push_run(input int n, input logic [15:0] base, input logic e, input logic one);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'h1;
      in_data <= base + 16'(i);
      in_start <= (i == 0);
      in_end <= e && (i == n - 1);
      in_one_byte <= one && (i == n - 1);
      in_abort <= abort_last && (i == n - 1);
      do @(posedge pclk); while (in_ready !== 1'h1);
    end
    in_valid <= 1'h0;
    @(posedge pclk);
  endtask : push_run

  function automatic int n_got();
    return rxrp_link_model_inst.got.size();
  endfunction : n_got

  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (n_got() < n && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    check_word("words read", n, n_got());
  endtask : wait_got

  task automatic t_regs();
    apb(1'h0, `RXRP_ADDR_CFG, 32'h0);
    check_word("cfg reset", 32'h0, rd);
    apb(1'h0, `RXRP_ADDR_THRESH, 32'h0);
    check_word("thresh reset", 32'(`RXRP_THRESH_RESET), rd);
    apb(1'h1, `RXRP_ADDR_THRESH, 32'hAB);
    apb(1'h0, `RXRP_ADDR_THRESH, 32'h0);
    check_word("thresh rw", 32'hAB, rd);
    apb(1'h0, 8'h0C, 32'h0);
    check_bit("unmapped err", 1'h1, err);
    check_word("unmapped read", 32'h0, rd);
    $display("test regs done");
  endtask : t_regs

  task automatic t_pkt();
    logic [20:0] w;
    logic [15:0] x;
    apb(1'h1, `RXRP_ADDR_CFG, 32'h12);
    active <= 1'h1;
    push_run(3, 16'hA1A5, 1'h1, 1'h1);
    edges(2);
    check_bit("packet avail end", 1'h1, pkt_av);
    want_read <= 1'h1;
    wait_got(3);
    abort_last = 1'h1;
    push_run(2, 16'hB2C3, 1'h1, 1'h0);
    abort_last = 1'h0;
    edges(4);
    check_bit("valid held", 1'h0, w_valid);
    check_bit("valid oe held", 1'h1, w_valid_oe);
    check_word("words held", 32'h3, n_got());
    apb(1'h0, `RXRP_ADDR_STATUS, 32'h0);
    check_word("level held", 32'h2, {24'h0, rd[7:0]});
    want_read <= 1'h0;
    edges(2);
    check_bit("valid oe off", 1'h0, w_valid_oe);
    check_bit("count oe off", 1'h0, w_cnt_oe);
    want_read <= 1'h1;
    wait_got(5);
    want_read <= 1'h0;
    edges(2);
    for (int i = 0; i < 5; i++) begin
      w = rxrp_link_model_inst.got[i];
      x = (i < 3) ? 16'hA1A5 + 16'(i) : 16'hB2C3 + 16'(i - 3);
      check_word("data", {16'h0, x[15:8], x[7:0] & {8{i != 2}}},
        {16'h0, w[15:8], w[7:0] & {8{i != 2}}});
      check_bit("parity", 1'h1, ^w[16:0]);
      check_bit("start", i == 0 || i == 3, w[19]);
      check_bit("end", i == 2 || i == 4, w[18]);
      check_bit("abort", i == 4, w[20]);
      if (w[18]) begin
        check_bit("one byte", i == 2, w[17]);
      end
    end
    $display("test packet done");
  endtask : t_pkt

  task automatic t_addr();
    code <= 3'h3;
    want_read <= 1'h1;
    edges(4);
    check_bit("oe other code", 1'h0, w_valid_oe);
    check_bit("bus oe other code", 1'h0, w_oe);
    check_bit("count oe other code", 1'h0, w_cnt_oe);
    want_read <= 1'h0;
    edges(2);
    apb(1'h1, `RXRP_ADDR_CFG, 32'h17);
    code <= 3'h7;
    want_read <= 1'h1;
    edges(4);
    check_bit("oe null code", 1'h0, w_valid_oe);
    want_read <= 1'h0;
    edges(2);
    apb(1'h1, `RXRP_ADDR_CFG, 32'h12);
    code <= 3'h2;
    want_read <= 1'h1;
    edges(4);
    check_bit("oe own code", 1'h1, w_valid_oe);
    check_bit("valid empty", 1'h0, w_valid);
    want_read <= 1'h0;
    edges(2);
    $display("test address done");
  endtask : t_addr

  task automatic t_avail();
    int b;
    apb(1'h1, `RXRP_ADDR_CFG, 32'h52);
    edges(2);
    check_bit("avail inverted", 1'h1, pkt_av);
    apb(1'h1, `RXRP_ADDR_CFG, 32'h12);
    apb(1'h1, `RXRP_ADDR_THRESH, 32'h4);
    push_run(1, 16'hC001, 1'h0, 1'h0);
    edges(2);
    check_bit("avail below", 1'h0, pkt_av);
    push_run(1, 16'hC002, 1'h0, 1'h0);
    edges(2);
    check_bit("avail at thresh", 1'h1, pkt_av);
    b = n_got();
    want_read <= 1'h1;
    wait_got(b + 2);
    want_read <= 1'h0;
    edges(2);
    $display("test avail done");
  endtask : t_avail

  task automatic t_cell();
    int b;
    int drop;
    for (int lvl = 0; lvl < 2; lvl++) begin
      drop = lvl ? 27 : 22;
      apb(1'h1, `RXRP_ADDR_CFG, lvl ? 32'h22 : 32'h02);
      push_run(27, 16'hD000, 1'h1, 1'h0);
      edges(2);
      check_bit("cell avail", 1'h1, cell_av);
      b = n_got();
      want_read <= 1'h1;
      wait_got(b + drop - 1);
      ticks(6);
      check_bit("cell avail before drop", 1'h1, cell_av);
      wait_got(b + drop);
      ticks(6);
      check_bit("cell avail after drop", 1'h0, cell_av);
      wait_got(b + 27);
      want_read <= 1'h0;
      edges(2);
    end
    $display("test cell done");
  endtask : t_cell

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    in_valid = 1'h0;
    in_data = 16'h0;
    in_start = 1'h0;
    in_end = 1'h0;
    in_one_byte = 1'h0;
    in_abort = 1'h0;
    abort_last = 1'h0;
    active = 1'h0;
    want_read = 1'h0;
    code = 3'h2;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    t_pkt();
    t_addr();
    t_avail();
    t_cell();
    complete_run();
  end
endmodule : rx_fifo_read_port_status_bench
`default_nettype wire
